// ---- sss_pkg.sv ----
// Package for the safe stop supervisor: sizes, defaults, timing counts, types.
// Assumes a 20 MHz system clock; positions and speeds in hundredths of a unit.
`default_nettype none
package sss_pkg;
    localparam int unsigned N_AXES        = 8;
    localparam int unsigned VAL_W         = 24;
    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned HOLD_DELAY_MS = 200;
    localparam int unsigned HOLD_DELAY_CYC = (CLK_HZ / 1000) * HOLD_DELAY_MS;
    localparam int unsigned DECEL_TIME_MS = 1000;
    localparam int unsigned DECEL_TIME_CYC = (CLK_HZ / 1000) * DECEL_TIME_MS;
    localparam int unsigned CNT_W         = 32;
    localparam logic [VAL_W-1:0] STOP_SPEED_DEF  = 24'h000064;
    localparam logic [VAL_W-1:0] HOLD_TRAVEL_DEF = 24'h000064;
    localparam logic [15:0] ERR_SS1_TIMEOUT = 16'h2280;
    localparam logic [15:0] ERR_SS2_TIMEOUT = 16'h2281;
    localparam logic [15:0] ERR_HOLD_MOVE   = 16'h2282;
    localparam logic [15:0] ERR_NONE        = 16'h0000;

    typedef logic [VAL_W-1:0] sss_val_t;

    typedef struct packed {
        sss_val_t [N_AXES-1:0] pos_cmd;
        sss_val_t [N_AXES-1:0] pos_fb;
        sss_val_t [N_AXES-1:0] spd_cmd;
        sss_val_t [N_AXES-1:0] spd_fb;
    } sss_axis_s;

    typedef struct packed {
        logic servo_on_req;
        logic servo_off_req;
        logic prog_start;
        logic jog_req;
        logic hand_req;
        logic motion_cmd;
    } sss_op_s;

    typedef struct packed {
        logic servo_on_ok;
        logic servo_off_ok;
        logic prog_start_ok;
        logic jog_ok;
        logic hand_ok;
    } sss_grant_s;

    typedef enum logic [2:0] {
        SSS_RUN, SSS_SS1, SSS_STO, SSS_SS2, SSS_HOLD, SSS_WAIT
    } sss_state_e;
endpackage
`default_nettype wire

// ---- sss_supervisor.sv ----
// Safe stop supervisor: category-1/2 stops, standstill holding, power cut-off.
// Assumes stop and e-stop inputs from pins; fault inputs and axis data are on the system clock.
// Functional notes
// - Raise hold-move error on holding violation
// - Holding only after category-2 deceleration
// - Default: stop2 suspends, start refused
// - Auto resume: suspend at motion, resume
// - Holding: servo-off, hand ok; jog refused
// - Servo-off during stop2 disables holding
// - Servo-on again: holding after 200 ms
// - Holding violation starts category-1 stop
// - Latch positions at holding start
// - Per-axis stop speed threshold, default 1.00
// - Per-axis travel limit, default 1.00
// - Stop1 request, e-stop, severe error trigger
// - Decelerate, then brake and cut power
// - Cut power on stopped or timeout
// - Stop1 timeout raises timeout error
// - Suspend until triggers clear and start
// - Stop1 not aborted until power cut
// - Clearing stop2 request returns to normal
// - No origin: cut power immediately
// - Separate stop speed set per axis
// - Deceleration time fixed constant
// - Holding keeps servos energised
// - Stop2 decelerates then holds, servos on
// - Forced cut-off on timeout or faults
`default_nettype none
module sss_supervisor (
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    input  wire logic                                  clk_en,
    input  wire logic                                  stop1_req_pin,
    input  wire logic                                  stop2_req_pin,
    input  wire logic                                  estop_pin,
    input  wire logic                                  severe_error,
    input  wire logic                                  ctrl_error,
    input  wire logic                                  ext_comm_fail,
    input  wire logic                                  origin_set,
    input  wire logic                                  auto_resume,
    input  wire logic [sss_pkg::N_AXES-1:0]            axis_enable,
    input  wire sss_pkg::sss_val_t [sss_pkg::N_AXES-1:0] stop_speed,
    input  wire sss_pkg::sss_val_t [sss_pkg::N_AXES-1:0] hold_travel,
    input  wire sss_pkg::sss_axis_s                    axis,
    input  wire logic                                  servo_is_on,
    input  wire sss_pkg::sss_op_s                      op,
    output var sss_pkg::sss_grant_s                    grant,
    output logic                                       decel_cmd,
    output logic                                       brake_lock,
    output logic                                       power_cut,
    output logic                                       prog_suspend,
    output logic                                       prog_resume,
    output logic                                       holding,
    output logic                                       error_flag,
    output logic [15:0]                                error_code
);
    localparam logic [sss_pkg::CNT_W-1:0] DECEL_LIM = sss_pkg::CNT_W'(sss_pkg::DECEL_TIME_CYC);
    localparam logic [sss_pkg::CNT_W-1:0] HOLD_LIM  = sss_pkg::CNT_W'(sss_pkg::HOLD_DELAY_CYC);

    function automatic sss_pkg::sss_val_t absdiff(input sss_pkg::sss_val_t a, input sss_pkg::sss_val_t b);
        absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
    endfunction

    function automatic sss_pkg::sss_val_t absval(input sss_pkg::sss_val_t a);
        absval = a[sss_pkg::VAL_W-1] ? sss_pkg::VAL_W'(-a) : a;
    endfunction

    logic [1:0] s1_sync, s2_sync, es_sync;
    logic       restart, cut_next;
    logic       stop1_in, stop2_in, estop_in;
    sss_pkg::sss_state_e state;
    sss_pkg::sss_val_t [sss_pkg::N_AXES-1:0] held_cmd, held_fb;
    logic [sss_pkg::CNT_W-1:0] timer;
    logic       all_stopped, cmd_zero, hold_violation, stop1_trig, stop2_pend;

    // Two-flop synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_sync <= 2'h0;
            s2_sync <= 2'h0;
            es_sync <= 2'h0;
        end else if (clk_en) begin
            s1_sync <= {s1_sync[0], stop1_req_pin};
            s2_sync <= {s2_sync[0], stop2_req_pin};
            es_sync <= {es_sync[0], estop_pin};
        end
    end
    assign stop1_in = s1_sync[1];
    assign stop2_in = s2_sync[1];
    assign estop_in = es_sync[1];

    assign stop1_trig = stop1_in | estop_in | severe_error;

    // Whole-robot stopped and holding checks
    always_comb begin
        all_stopped    = 1'b1;
        cmd_zero       = 1'b1;
        hold_violation = 1'b0;
        for (int i = 0; i < sss_pkg::N_AXES; i++) begin
            if (axis_enable[i]) begin
                if (absval(axis.spd_fb[i]) >= stop_speed[i] ||
                    absval(axis.spd_cmd[i]) >= stop_speed[i])
                    all_stopped = 1'b0;
                if (axis.spd_cmd[i] != '0)
                    cmd_zero = 1'b0;
                if (absdiff(axis.pos_cmd[i], held_cmd[i]) > hold_travel[i] ||
                    absdiff(axis.pos_fb[i], held_fb[i]) > hold_travel[i] ||
                    absval(axis.spd_cmd[i]) > stop_speed[i] ||
                    absval(axis.spd_fb[i]) > stop_speed[i])
                    hold_violation = 1'b1;
            end
        end
    end

    // Main stop sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= sss_pkg::SSS_RUN;
            timer      <= '0;
            error_code <= sss_pkg::ERR_NONE;
            error_flag <= 1'b0;
        end else if (clk_en) begin
            unique case (state)
                sss_pkg::SSS_RUN: begin
                    timer <= '0;
                    if (ctrl_error || ext_comm_fail) begin
                        state <= sss_pkg::SSS_STO;
                    end else if (stop1_trig || hold_violation && 1'b0) begin
                        state <= origin_set ? sss_pkg::SSS_SS1 : sss_pkg::SSS_STO;
                    end else if (stop2_in && servo_is_on) begin
                        state <= sss_pkg::SSS_SS2;
                    end
                end
                sss_pkg::SSS_SS1: begin
                    timer <= timer + 1'b1;
                    if (ctrl_error || ext_comm_fail) begin
                        state <= sss_pkg::SSS_STO;
                    end else if ((cmd_zero && all_stopped)) begin
                        state <= sss_pkg::SSS_STO;
                    end else if (timer >= DECEL_LIM - 1'b1) begin
                        state      <= sss_pkg::SSS_STO;
                        error_code <= sss_pkg::ERR_SS1_TIMEOUT;
                        error_flag <= 1'b1;
                    end
                end
                sss_pkg::SSS_STO: begin
                    timer <= '0;
                    if (!stop1_trig && !ctrl_error && !ext_comm_fail && op.prog_start) begin
                        state      <= sss_pkg::SSS_RUN;
                        error_flag <= 1'b0;
                        error_code <= sss_pkg::ERR_NONE;
                    end
                end
                sss_pkg::SSS_SS2: begin
                    timer <= timer + 1'b1;
                    if (ctrl_error || ext_comm_fail) begin
                        state <= sss_pkg::SSS_STO;
                    end else if (stop1_trig) begin
                        state <= origin_set ? sss_pkg::SSS_SS1 : sss_pkg::SSS_STO;
                        timer <= '0;
                    end else if (cmd_zero && all_stopped) begin
                        state <= sss_pkg::SSS_HOLD;
                    end else if (timer >= DECEL_LIM - 1'b1) begin
                        state      <= sss_pkg::SSS_STO;
                        error_code <= sss_pkg::ERR_SS2_TIMEOUT;
                        error_flag <= 1'b1;
                    end
                end
                sss_pkg::SSS_HOLD: begin
                    timer <= '0;
                    if (ctrl_error || ext_comm_fail) begin
                        state <= sss_pkg::SSS_STO;
                    end else if (hold_violation) begin
                        state      <= origin_set ? sss_pkg::SSS_SS1 : sss_pkg::SSS_STO;
                        error_code <= sss_pkg::ERR_HOLD_MOVE;
                        error_flag <= 1'b1;
                    end else if (stop1_trig) begin
                        state <= origin_set ? sss_pkg::SSS_SS1 : sss_pkg::SSS_STO;
                    end else if (!servo_is_on) begin
                        state <= sss_pkg::SSS_WAIT;
                    end else if (!stop2_in) begin
                        state <= sss_pkg::SSS_RUN;
                    end
                end
                sss_pkg::SSS_WAIT: begin
                    timer <= servo_is_on ? timer + 1'b1 : '0;
                    if (stop1_trig || ctrl_error || ext_comm_fail) begin
                        state <= (origin_set && !ctrl_error && !ext_comm_fail) ? sss_pkg::SSS_SS1 : sss_pkg::SSS_STO;
                        timer <= '0;
                    end else if (!stop2_in) begin
                        state <= sss_pkg::SSS_RUN;
                    end else if (servo_is_on && timer >= HOLD_LIM - 1'b1) begin
                        state <= sss_pkg::SSS_HOLD;
                    end
                end
            endcase
        end
    end

    // Latch held positions on entry to holding
    always_ff @(posedge clk) begin
        if (reset) begin
            held_cmd <= '0;
            held_fb  <= '0;
        end else if (clk_en && state != sss_pkg::SSS_HOLD) begin
            held_cmd <= axis.pos_cmd;
            held_fb  <= axis.pos_fb;
        end
    end

    // Restart from cut-off, and entry to a category-1 stop or cut-off
    assign restart  = state == sss_pkg::SSS_STO && !stop1_trig && !ctrl_error && !ext_comm_fail && op.prog_start;
    assign cut_next = stop1_trig || ctrl_error || ext_comm_fail ||
                      (state == sss_pkg::SSS_HOLD && hold_violation) ||
                      (state == sss_pkg::SSS_SS2 && timer >= DECEL_LIM - 1'b1);

    // Program suspend and resume
    always_ff @(posedge clk) begin
        if (reset) begin
            prog_suspend <= 1'b0;
            prog_resume  <= 1'b0;
            stop2_pend   <= 1'b0;
        end else if (clk_en) begin
            prog_resume <= 1'b0;
            if (restart) begin
                prog_suspend <= 1'b0;
                prog_resume  <= 1'b1;
                stop2_pend   <= 1'b0;
            end else if (state == sss_pkg::SSS_SS1 || state == sss_pkg::SSS_STO || cut_next) begin
                prog_suspend <= 1'b1;
                stop2_pend   <= 1'b0;
            end else if (stop2_in) begin
                if (!auto_resume || op.motion_cmd)
                    prog_suspend <= 1'b1;
                stop2_pend <= auto_resume;
            end else if (stop2_pend) begin
                prog_suspend <= 1'b0;
                prog_resume  <= prog_suspend;
                stop2_pend   <= 1'b0;
            end else if (prog_suspend && op.prog_start && state == sss_pkg::SSS_RUN) begin
                prog_suspend <= 1'b0;
                prog_resume  <= 1'b1;
            end
        end
    end

    // Operation grants
    always_comb begin
        grant.servo_on_ok   = state != sss_pkg::SSS_SS1;
        grant.servo_off_ok  = 1'b1;
        grant.hand_ok       = 1'b1;
        grant.jog_ok        = state == sss_pkg::SSS_RUN && !stop2_in;
        grant.prog_start_ok = (state == sss_pkg::SSS_RUN && (!stop2_in || auto_resume)) ||
                              ((state == sss_pkg::SSS_HOLD || state == sss_pkg::SSS_WAIT) && auto_resume) ||
                              (state == sss_pkg::SSS_STO && !stop1_trig);
    end

    assign decel_cmd  = state == sss_pkg::SSS_SS1 || state == sss_pkg::SSS_SS2;
    assign brake_lock = state == sss_pkg::SSS_STO;
    assign power_cut  = state == sss_pkg::SSS_STO;
    assign holding    = state == sss_pkg::SSS_HOLD;
endmodule
`default_nettype wire

// ---- sss_supervisor_asserts.sv ----
// Checker for the safe stop supervisor, bound to its top module.
// Assumes clk_en is held high by the bench.
`default_nettype none
module sss_supervisor_asserts (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                stop1_req_pin,
    input wire logic                stop2_req_pin,
    input wire logic                estop_pin,
    input wire logic                origin_set,
    input wire logic                auto_resume,
    input wire sss_pkg::sss_grant_s grant,
    input wire logic                decel_cmd,
    input wire logic                brake_lock,
    input wire logic                power_cut,
    input wire logic                prog_suspend,
    input wire logic                holding
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    hold_power_on_a: assert property (holding |-> !power_cut && !brake_lock)
        else $error("power removed while holding");
    hold_grants_a: assert property (holding |-> !grant.jog_ok && grant.servo_off_ok && grant.hand_ok)
        else $error("wrong grants while holding");
    hold_start_a: assert property (holding |-> grant.prog_start_ok == auto_resume)
        else $error("start grant wrong while holding");
    hold_entry_a: assert property ($rose(holding) |-> $past(stop2_req_pin, 2))
        else $error("holding without stop request");
    cut_brake_a: assert property (power_cut |-> brake_lock)
        else $error("power cut without brake");
    cut_suspend_a: assert property ($rose(power_cut) |-> prog_suspend)
        else $error("program runs during cut");
    estop_react_a: assert property ($rose(estop_pin) |-> ##[1:4] (decel_cmd || power_cut))
        else $error("no stop after emergency");
    no_origin_a: assert property ($rose(stop1_req_pin) && !origin_set |-> ##[1:4] power_cut)
        else $error("no immediate cut without origin");
    stop1_keep_a: assert property ($fell(stop1_req_pin) && decel_cmd |=> decel_cmd || power_cut)
        else $error("deceleration aborted");
endmodule
bind sss_supervisor sss_supervisor_asserts chk_u (.clk, .reset, .stop1_req_pin, .stop2_req_pin, .estop_pin,
    .origin_set, .auto_resume, .grant, .decel_cmd, .brake_lock, .power_cut, .prog_suspend, .holding);
`default_nettype wire

// ---- sss_servo_model.sv ----
// Servo side model: speed ramp, position offset on one axis, servo state.
// Assumes the bench drives run speed, offsets and servo requests.
`default_nettype none
module sss_servo_model (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              stop_cmd,
    input  wire logic              cut,
    input  wire logic              servo_req,
    input  wire sss_pkg::sss_val_t run_spd,
    input  wire sss_pkg::sss_val_t nudge,
    input  wire logic [2:0]        nax,
    output var sss_pkg::sss_axis_s axis,
    output logic                   servo_is_on
);
    timeunit 1ns;
    timeprecision 1ns;
    sss_pkg::sss_val_t spd;
    sss_pkg::sss_val_t off;
    // Ramp down while stopping
    always_ff @(posedge clk) begin
        if (reset) spd <= '0;
        else if (!stop_cmd) spd <= run_spd;
        else spd <= (spd > 24'h20) ? spd - 24'h20 : 24'h0;
    end
    always_ff @(posedge clk) begin
        off <= reset ? '0 : off + nudge;
        servo_is_on <= !reset && servo_req && !cut;
    end
    always_comb begin
        axis = '0;
        for (int i = 0; i < sss_pkg::N_AXES; i++) begin
            axis.spd_cmd[i] = spd;
            axis.spd_fb[i] = spd;
        end
        axis.pos_fb[nax] = off;
    end
endmodule
`default_nettype wire

// ---- sss_supervisor_tb.sv ----
// Self-checking bench for the safe stop supervisor.
// Assumes a 50 ns clock; long monitoring times are not reached.
`default_nettype none
module sss_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [4:0] trig = '0;
    logic stop2 = 1'b0;
    logic origin_set = 1'b1;
    logic auto_resume = 1'b0;
    logic servo_req = 1'b1;
    logic [sss_pkg::N_AXES-1:0] axis_enable = '1;
    sss_pkg::sss_val_t [sss_pkg::N_AXES-1:0] stop_speed = {sss_pkg::N_AXES{sss_pkg::STOP_SPEED_DEF}};
    sss_pkg::sss_val_t [sss_pkg::N_AXES-1:0] hold_travel = {sss_pkg::N_AXES{sss_pkg::HOLD_TRAVEL_DEF}};
    sss_pkg::sss_val_t run_spd = '0;
    sss_pkg::sss_val_t nudge = '0;
    logic [2:0] nax = '0;
    sss_pkg::sss_op_s op = '0;
    sss_pkg::sss_axis_s axis;
    sss_pkg::sss_grant_s grant;
    logic servo_is_on, decel_cmd, brake_lock, power_cut, prog_suspend, prog_resume, holding, error_flag;
    logic [15:0] error_code;
    int miscompares = 0;
    int n_compared = 0;
    int n1, n2;
    sss_supervisor dut_u (.clk, .reset, .clk_en, .stop1_req_pin(trig[0]), .stop2_req_pin(stop2),
        .estop_pin(trig[1]), .severe_error(trig[2]), .ctrl_error(trig[3]), .ext_comm_fail(trig[4]),
        .origin_set, .auto_resume, .axis_enable, .stop_speed, .hold_travel, .axis, .servo_is_on, .op,
        .grant, .decel_cmd, .brake_lock, .power_cut, .prog_suspend, .prog_resume, .holding,
        .error_flag, .error_code);
    sss_servo_model model_u (.clk, .reset, .stop_cmd(decel_cmd | holding | power_cut), .cut(power_cut),
        .servo_req, .run_spd, .nudge, .nax, .axis, .servo_is_on);
    initial forever #25 clk = ~clk;
    task automatic chk(input logic exp, input logic got, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic chk_code(input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t error code %h", $time, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 300 && s !== 1'b1; i++) cyc(1);
    endtask
    task automatic start_pulse;
        op.prog_start = 1'b1;
        cyc(1);
        op.prog_start = 1'b0;
    endtask
    function automatic logic over_travel(input int d);
        return d > int'(sss_pkg::HOLD_TRAVEL_DEF);
    endfunction
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(29529));
        cyc(16);
        reset = 1'b0;
        run_spd = 24'h100 + 24'($urandom_range(0, 255));
        cyc(4);
        // Category-2 stop into holding
        stop2 = 1'b1;
        wait_hi(holding);
        chk(1'b1, holding, "no holding");
        chk(1'b0, power_cut, "power cut in holding");
        chk(1'b0, grant.jog_ok | grant.prog_start_ok, "grant in holding");
        chk(1'b1, grant.servo_off_ok & grant.hand_ok, "grant missing");
        start_pulse();
        cyc(3);
        chk(1'b1, prog_suspend, "start accepted");
        // Travel boundary, then violation on a random axis
        nax = 3'($urandom_range(0, 7));
        n1 = $urandom_range(0, 100);
        nudge = 24'(n1);
        cyc(1);
        nudge = '0;
        cyc(5);
        chk(over_travel(n1), error_flag, "travel limit");
        n2 = 101 - n1 + $urandom_range(0, 3);
        nudge = 24'(n2);
        cyc(1);
        nudge = '0;
        wait_hi(error_flag);
        chk(over_travel(n1 + n2), error_flag, "no travel error");
        chk_code(sss_pkg::ERR_HOLD_MOVE, error_code);
        chk(1'b1, decel_cmd | power_cut, "no stop");
        wait_hi(power_cut);
        chk(1'b1, brake_lock, "no brake");
        stop2 = 1'b0;
        cyc(4);
        start_pulse();
        cyc(3);
        chk(1'b0, power_cut | error_flag, "no restart");
        // Servo off and on during holding
        run_spd = '0;
        stop2 = 1'b1;
        wait_hi(holding);
        servo_req = 1'b0;
        cyc(4);
        chk(1'b0, holding, "holding with servo off");
        servo_req = 1'b1;
        cyc(40);
        chk(1'b0, holding, "holding too early");
        stop2 = 1'b0;
        cyc(4);
        chk(1'b0, decel_cmd | holding, "not back to run");
        start_pulse();
        cyc(3);
        // Automatic resumption
        auto_resume = 1'b1;
        stop2 = 1'b1;
        cyc(4);
        op.motion_cmd = 1'b1;
        cyc(1);
        op.motion_cmd = 1'b0;
        wait_hi(holding);
        chk(1'b1, grant.prog_start_ok, "start refused");
        stop2 = 1'b0;
        wait_hi(prog_resume);
        chk(1'b1, prog_resume, "no auto resume");
        auto_resume = 1'b0;
        cyc(4);
        // Every category-1 and forced cut trigger
        for (int k = 0; k < 5; k++) begin
            run_spd = 24'h100 + 24'($urandom_range(0, 255));
            cyc(4);
            trig = 5'(1 << k);
            cyc(4);
            chk(1'b1, (k < 3) ? decel_cmd : power_cut, "trigger reaction");
            if (k == 0) trig = '0;
            cyc(1);
            chk(1'b1, decel_cmd | power_cut, "stop aborted");
            wait_hi(power_cut);
            chk(1'b1, prog_suspend & brake_lock, "not suspended");
            start_pulse();
            cyc(3);
            chk(k != 0, power_cut, "start with trigger");
            trig = '0;
            cyc(4);
            start_pulse();
            cyc(3);
            chk(1'b0, power_cut | prog_suspend, "no return");
        end
        // No origin: immediate cut
        origin_set = 1'b0;
        trig = 5'h01;
        cyc(4);
        chk(1'b1, power_cut & !decel_cmd, "no direct cut");
        trig = '0;
        origin_set = 1'b1;
        tally_and_finish();
    end
endmodule
`default_nettype wire
